// ==== hdl/swts_defs.svh ====
// constants for the single-wire temperature sensor slave
// assumes a 50 MHz ref_clk_in; times are in microseconds unless named otherwise
`ifndef SWTS_DEFS_SVH
`define SWTS_DEFS_SVH

`define SWTS_CLK_MHZ          50
`define SWTS_RESET_DET_US     120
`define SWTS_RESET_DET_CYC    (`SWTS_RESET_DET_US * `SWTS_CLK_MHZ)
`define SWTS_PRES_WAIT_US     30
`define SWTS_PRES_WAIT_CYC    (`SWTS_PRES_WAIT_US * `SWTS_CLK_MHZ)
`define SWTS_PRES_LOW_US      120
`define SWTS_PRES_LOW_CYC     (`SWTS_PRES_LOW_US * `SWTS_CLK_MHZ)
`define SWTS_SLOT_DLY_US      30
`define SWTS_SLOT_DLY_CYC     (`SWTS_SLOT_DLY_US * `SWTS_CLK_MHZ)
`define SWTS_CONV_MS          500
`define SWTS_CONV_CYC         (`SWTS_CONV_MS * 1000 * `SWTS_CLK_MHZ)
`define SWTS_COPY_MS          10
`define SWTS_COPY_CYC         (`SWTS_COPY_MS * 1000 * `SWTS_CLK_MHZ)

`define SWTS_ROM_READ         8'h33
`define SWTS_ROM_MATCH        8'h55
`define SWTS_ROM_SKIP         8'hcc
`define SWTS_FN_CONVERT       8'h44
`define SWTS_FN_READ_SP       8'hbe
`define SWTS_FN_WRITE_SP      8'h4e
`define SWTS_FN_COPY_SP       8'h48
`define SWTS_FN_RECALL        8'hb8

`define SWTS_SP_UPPER         4'h2
`define SWTS_SP_LOWER         4'h3
`define SWTS_SP_CRC           4'h8
`define SWTS_SP_LAST          4'h8
`define SWTS_TRIG_RESET       8'h00
`define SWTS_CRC_POLY_REV     8'h8c

`endif

// ==== hdl/swts_pkg.sv ====
// types shared by the single-wire temperature sensor slave
// assumes swts_defs.svh supplies the numeric constants
package swts_pkg;
	typedef enum logic [3:0] {
		SWTS_IDLE,
		SWTS_PRES_WAIT,
		SWTS_PRES_LOW,
		SWTS_ROM_CMD,
		SWTS_ROM_MATCH,
		SWTS_FN_CMD,
		SWTS_WRITE_SP,
		SWTS_READ_SP,
		SWTS_READ_ROM,
		SWTS_BUSY,
		SWTS_WAIT_RESET
	} swts_state_e;
endpackage

// ==== hdl/swts_buf2.sv ====
// two-entry valid/ready buffer for bytes moving toward the storage side
// assumes a single clock and a consumer that may stall at any time
module swts_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             resetn_in,
	// filling side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	logic [WIDTH-1:0] slot_mem [2];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	logic             push;
	logic             pop;

	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	// pointers and occupancy; full refuses new words rather than dropping them
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// storage
	always_ff @(posedge ref_clk_in) begin
		if (push)
			slot_mem[wr_ptr] <= in_data_in;
	end

	assign in_ready_out  = (count != 2'h2);
	assign out_valid_out = (count != 2'h0);
	assign out_data_out  = slot_mem[rd_ptr];
endmodule

// ==== hdl/swts_slave.sv ====
// single-wire bus slave: reset/presence, bit slots, rom match and function commands
// assumes a synchronous, glitch-free line input and an external open-drain pad
`include "swts_defs.svh"
module swts_slave #(
	parameter logic [63:0] OWN_ROM      = 64'h0000_0000_0000_0128, // arbitrary value
	parameter int          CONV_CYC     = `SWTS_CONV_CYC,
	parameter int          COPY_CYC     = `SWTS_COPY_CYC,
	parameter int          SLOT_DLY_CYC = `SWTS_SLOT_DLY_CYC
) (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        resetn_in,
	// bus pin, open drain: oe low means the device pulls the line low
	input  wire logic        line_in,
	output logic             line_out,
	output logic             line_oe_n_out,
	// temperature front end
	input  wire logic [15:0] temp_value_in,
	input  wire logic [7:0]  count_remain_in,
	input  wire logic [7:0]  count_per_deg_in,
	output logic             conv_start_out,
	output logic             conv_busy_out,
	// nonvolatile trigger storage
	output logic             nv_write_out,
	output logic [15:0]      nv_data_out,
	input  wire logic [15:0] nv_data_in,
	input  wire logic        nv_ready_in,
	// status
	output logic             present_out
);
	localparam int RST_CYC  = `SWTS_RESET_DET_CYC;
	localparam int PW_CYC   = `SWTS_PRES_WAIT_CYC;
	localparam int PL_CYC   = `SWTS_PRES_LOW_CYC;
	localparam int CW       = 25;

	swts_pkg::swts_state_e state;
	logic          line_d;
	logic [CW-1:0] low_cnt;
	logic [CW-1:0] tmr;
	logic          in_slot;
	logic          drive_low;
	logic          fall;
	logic          slot_done;
	logic          bit_val;
	logic [7:0]    sh;
	logic [2:0]    bit_idx;
	logic [5:0]    rom_idx;
	logic [3:0]    byte_idx;
	logic [7:0]    upper_trig;
	logic [7:0]    lower_trig;
	logic [7:0]    crc;
	logic          copy_pend;
	logic          bw_valid;
	logic          bw_ready;
	logic [7:0]    bw_data;
	logic          bd_valid;
	logic [7:0]    bd_data;
	logic          bd_sel;
	logic [7:0]    tx_byte;
	logic          tx_bit;
	logic          nv_reload;
	logic          tmr_reset_seen;

	assign fall = line_d && !line_in;

	// line history and master low time; our own presence pull-down must not look like a reset
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_d  <= 1'b1;
			low_cnt <= '0;
		end else begin
			line_d  <= line_in;
			low_cnt <= (line_in || drive_low || !line_oe_n_out) ? '0 : low_cnt + CW'(1);
		end
	end

	// scratchpad byte to send, least significant bit first
	always_comb begin
		unique case (byte_idx)
			4'h0:    tx_byte = temp_value_in[7:0];
			4'h1:    tx_byte = temp_value_in[15:8];
			4'h2:    tx_byte = upper_trig;
			4'h3:    tx_byte = lower_trig;
			4'h6:    tx_byte = count_remain_in;
			4'h7:    tx_byte = count_per_deg_in;
			4'h8:    tx_byte = crc;
			default: tx_byte = 8'hff;
		endcase
		if (state == swts_pkg::SWTS_READ_ROM)
			tx_bit = OWN_ROM[rom_idx];
		else
			tx_bit = tx_byte[bit_idx];
	end

	// slot timer: started by the master's falling edge, ends after the internal delay
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			in_slot   <= 1'b0;
			slot_done <= 1'b0;
			bit_val   <= 1'b0;
		end else begin
			slot_done <= 1'b0;
			if (fall && !in_slot && state != swts_pkg::SWTS_PRES_LOW) begin
				in_slot <= 1'b1;
			end else if (in_slot && tmr == CW'(SLOT_DLY_CYC - 1)) begin
				in_slot   <= 1'b0;
				slot_done <= 1'b1;
				bit_val   <= line_in;
			end
		end
	end

	// main sequencer; a line low past the reset threshold returns it to idle and clears presence, busy and copy
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state     <= swts_pkg::SWTS_IDLE;
			tmr       <= '0;
			sh        <= 8'h00;
			bit_idx   <= 3'h0;
			rom_idx   <= 6'h0;
			byte_idx  <= 4'h0;
			drive_low <= 1'b0;
			crc       <= 8'h00;
			copy_pend <= 1'b0;
			conv_start_out <= 1'b0;
			conv_busy_out  <= 1'b0;
			bw_valid  <= 1'b0;
			bw_data   <= 8'h00;
			present_out <= 1'b0;
		end else begin
			conv_start_out <= 1'b0;
			if (bw_valid && bw_ready)
				bw_valid <= 1'b0;
			if (fall && !in_slot)
				tmr <= '0;
			else
				tmr <= tmr + CW'(1);
			if (low_cnt >= CW'(RST_CYC)) begin
				state     <= swts_pkg::SWTS_IDLE;
				drive_low <= 1'b0;
				copy_pend <= 1'b0;
				conv_busy_out <= 1'b0;
				present_out <= 1'b0;
			end else begin
				unique case (state)
					swts_pkg::SWTS_IDLE: begin
						// the rise cycle itself still sits in the reset branch; start one edge later
						if (line_in && tmr_reset_seen) begin
							state <= swts_pkg::SWTS_PRES_WAIT;
							tmr   <= '0;
						end
					end
					swts_pkg::SWTS_PRES_WAIT: begin
						if (tmr == CW'(PW_CYC - 1)) begin
							state     <= swts_pkg::SWTS_PRES_LOW;
							drive_low <= 1'b1;
							tmr       <= '0;
						end
					end
					swts_pkg::SWTS_PRES_LOW: begin
						if (tmr == CW'(PL_CYC - 1)) begin
							drive_low   <= 1'b0;
							present_out <= 1'b1;
							state       <= swts_pkg::SWTS_ROM_CMD;
							bit_idx     <= 3'h0;
						end
					end
					swts_pkg::SWTS_ROM_CMD, swts_pkg::SWTS_FN_CMD,
					swts_pkg::SWTS_WRITE_SP: begin
						if (slot_done) begin
							sh      <= {bit_val, sh[7:1]};
							bit_idx <= bit_idx + 3'h1;
							if (bit_idx == 3'h7)
								byte_done({bit_val, sh[7:1]});
						end
					end
					swts_pkg::SWTS_ROM_MATCH: begin
						if (slot_done) begin
							rom_idx <= rom_idx + 6'h1;
							if (bit_val != OWN_ROM[rom_idx])
								state <= swts_pkg::SWTS_WAIT_RESET;
							else if (rom_idx == 6'h3f)
								state <= swts_pkg::SWTS_FN_CMD;
						end
					end
					swts_pkg::SWTS_READ_ROM: begin
						if (fall && !in_slot)
							drive_low <= !tx_bit;
						if (slot_done) begin
							drive_low <= 1'b0;
							rom_idx   <= rom_idx + 6'h1;
							if (rom_idx == 6'h3f)
								state <= swts_pkg::SWTS_FN_CMD;
						end
					end
					swts_pkg::SWTS_READ_SP: begin
						if (fall && !in_slot)
							drive_low <= !tx_bit;
						if (slot_done) begin
							drive_low <= 1'b0;
							bit_idx   <= bit_idx + 3'h1;
							if (byte_idx != `SWTS_SP_CRC)
								crc <= crc_step(crc, tx_bit);
							if (bit_idx == 3'h7) begin
								byte_idx <= byte_idx + 4'h1;
								if (byte_idx == `SWTS_SP_LAST)
									state <= swts_pkg::SWTS_WAIT_RESET;
							end
						end
					end
					swts_pkg::SWTS_BUSY: begin
						// internal work powered by the master's active pull-up
						if (tmr == CW'(copy_pend ? COPY_CYC - 1 : CONV_CYC - 1)) begin
							conv_busy_out <= 1'b0;
							copy_pend     <= 1'b0;
							state         <= swts_pkg::SWTS_WAIT_RESET;
						end
					end
					swts_pkg::SWTS_WAIT_RESET: begin
					end
					default: state <= swts_pkg::SWTS_IDLE;
				endcase
			end
		end
	end

	// a full reset-length low has been seen since the last presence
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			tmr_reset_seen <= 1'b0;
		else if (low_cnt >= CW'(RST_CYC))
			tmr_reset_seen <= 1'b1;
		else if (state == swts_pkg::SWTS_PRES_WAIT)
			tmr_reset_seen <= 1'b0;
	end

	// crc over one bit, reflected polynomial, lsb first
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		return fb ? ((c >> 1) ^ `SWTS_CRC_POLY_REV) : (c >> 1);
	endfunction

	// decision after each whole received byte; a task keeps the sequencer readable
	task automatic byte_done(input logic [7:0] v);
		bit_idx <= 3'h0;
		rom_idx <= 6'h0;
		unique case (state)
			swts_pkg::SWTS_ROM_CMD: begin
				if (v == `SWTS_ROM_MATCH)
					state <= swts_pkg::SWTS_ROM_MATCH;
				else if (v == `SWTS_ROM_SKIP)
					state <= swts_pkg::SWTS_FN_CMD;
				else if (v == `SWTS_ROM_READ)
					state <= swts_pkg::SWTS_READ_ROM;
				else
					state <= swts_pkg::SWTS_WAIT_RESET;
			end
			swts_pkg::SWTS_FN_CMD: begin
				byte_idx <= 4'h0;
				crc      <= 8'h00;
				if (v == `SWTS_FN_CONVERT) begin
					conv_start_out <= 1'b1;
					conv_busy_out  <= 1'b1;
					tmr            <= '0;
					state          <= swts_pkg::SWTS_BUSY;
				end else if (v == `SWTS_FN_READ_SP) begin
					state <= swts_pkg::SWTS_READ_SP;
				end else if (v == `SWTS_FN_WRITE_SP) begin
					byte_idx <= `SWTS_SP_UPPER;
					state    <= swts_pkg::SWTS_WRITE_SP;
				end else if (v == `SWTS_FN_COPY_SP) begin
					copy_pend <= 1'b1;
					tmr       <= '0;
					state     <= swts_pkg::SWTS_BUSY;
				end else if (v == `SWTS_FN_RECALL) begin
					state <= swts_pkg::SWTS_WAIT_RESET;
				end else begin
					state <= swts_pkg::SWTS_WAIT_RESET;
				end
			end
			default: begin
				// scratchpad write: byte goes through the buffer untagged; its arrival order picks upper or lower
				bw_valid <= 1'b1;
				bw_data  <= v;
				byte_idx <= byte_idx + 4'h1;
				if (byte_idx == `SWTS_SP_LOWER)
					state <= swts_pkg::SWTS_WAIT_RESET;
			end
		endcase
	endtask

	swts_buf2 #(.WIDTH(8)) u_wbuf (
		.ref_clk_in    (ref_clk_in),
		.resetn_in     (resetn_in),
		.in_valid_in   (bw_valid),
		.in_ready_out  (bw_ready),
		.in_data_in    (bw_data),
		.out_valid_out (bd_valid),
		.out_ready_in  (1'b1),
		.out_data_out  (bd_data)
	);

	// trigger bytes land alternately in upper then lower; only these are writable
	assign nv_reload = (state == swts_pkg::SWTS_FN_CMD) && slot_done && bit_idx == 3'h7
		&& {bit_val, sh[7:1]} == `SWTS_FN_RECALL;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			upper_trig <= `SWTS_TRIG_RESET;
			lower_trig <= `SWTS_TRIG_RESET;
			bd_sel     <= 1'b0;
		end else if (nv_reload && nv_ready_in) begin
			upper_trig <= nv_data_in[7:0];
			lower_trig <= nv_data_in[15:8];
		end else if (bd_valid) begin
			bd_sel <= ~bd_sel;
			if (!bd_sel)
				upper_trig <= bd_data;
			else
				lower_trig <= bd_data;
		end else if (state == swts_pkg::SWTS_FN_CMD) begin
			bd_sel <= 1'b0;
		end
	end

	// copy request to storage, one pulse at the start of the copy interval
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			nv_write_out <= 1'b0;
			nv_data_out  <= 16'h0000;
		end else begin
			nv_write_out <= copy_pend && state == swts_pkg::SWTS_BUSY && tmr == '0;
			nv_data_out  <= {lower_trig, upper_trig};
		end
	end

	// pad drive from a flop: output low and enable active while pulling down
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_out      <= 1'b1;
			line_oe_n_out <= 1'b1;
		end else begin
			line_out      <= 1'b0;
			line_oe_n_out <= !drive_low;
		end
	end
endmodule

// ==== sim/swts_slave_props.sv ====
// port-level properties of the single-wire slave
// assumes binding to swts_slave; the line input already resolves all drivers
module swts_slave_props #(
	parameter int CONV_CYC     = 200,
	parameter int SLOT_DLY_CYC = 100
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_oe_n_out,
	input wire logic conv_start_out,
	input wire logic conv_busy_out,
	input wire logic nv_write_out,
	input wire logic present_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] low_cnt;
	logic [31:0] high_cnt;
	logic [31:0] busy_cnt;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	// run lengths: device drive, high line, conversion busy
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			low_cnt  <= 32'h0;
			high_cnt <= 32'h0;
			busy_cnt <= 32'h0;
		end else begin
			low_cnt  <= line_oe_n_out ? 32'h0 : low_cnt + 32'h1;
			high_cnt <= line_in ? high_cnt + 32'h1 : 32'h0;
			busy_cnt <= conv_busy_out ? busy_cnt + 32'h1 : 32'h0;
		end
	end

	property p_drive_low_only;
		!line_oe_n_out |-> !line_out;
	endproperty
	a_drive_low_only: assert property (p_drive_low_only)
		else $error("device drives the line high");
	// presence must follow the released line by 15 to 60 us
	property p_pres_wait;
		$fell(line_oe_n_out) && !present_out |-> high_cnt >= 750 && high_cnt <= 3000;
	endproperty
	a_pres_wait: assert property (p_pres_wait)
		else $error("presence wait out of range");
	property p_pres_len;
		$rose(line_oe_n_out) && low_cnt > SLOT_DLY_CYC + 8 |-> low_cnt >= 3000 && low_cnt <= 12000;
	endproperty
	a_pres_len: assert property (p_pres_len)
		else $error("presence length out of range");
	property p_zero_len;
		$rose(line_oe_n_out) |-> low_cnt >= SLOT_DLY_CYC - 4;
	endproperty
	a_zero_len: assert property (p_zero_len)
		else $error("read zero released early");
	// a slot drive is only ever a reply to the master's falling edge
	property p_slot_cause;
		$fell(line_oe_n_out) && present_out |-> !$past(line_in);
	endproperty
	a_slot_cause: assert property (p_slot_cause)
		else $error("device drive without master edge");
	property p_conv_start;
		conv_start_out |=> !conv_start_out ##0 conv_busy_out;
	endproperty
	a_conv_start: assert property (p_conv_start)
		else $error("conversion start not a single pulse into busy");
	property p_conv_bound;
		conv_busy_out |-> busy_cnt <= CONV_CYC + 2;
	endproperty
	a_conv_bound: assert property (p_conv_bound)
		else $error("conversion overruns its time");
	property p_nv_pulse;
		nv_write_out |=> !nv_write_out [*2];
	endproperty
	a_nv_pulse: assert property (p_nv_pulse)
		else $error("storage write not a single pulse");

	c_presence: cover property ($fell(line_oe_n_out) && !present_out);
	c_read_zero: cover property ($rose(line_oe_n_out) && present_out);
	c_convert: cover property (conv_start_out);
	c_copy: cover property (nv_write_out);
endmodule

bind swts_slave swts_slave_props #(.CONV_CYC(CONV_CYC), .SLOT_DLY_CYC(SLOT_DLY_CYC))
	swts_slave_props_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .line_in(line_in),
	.line_out(line_out), .line_oe_n_out(line_oe_n_out), .conv_start_out(conv_start_out),
	.conv_busy_out(conv_busy_out), .nv_write_out(nv_write_out), .present_out(present_out));

// ==== sim/swts_master_model.sv ====
// bus master model: reset, presence timing, write and read slots
// assumes a pull-up resolves the line; slot lengths scale with the slave delay
module swts_master_model #(
	parameter int SLOT_DLY_CYC = 100,
	parameter int RST_LOW_CYC  = 24000 // 480 us at 50 MHz, below the 960 us ceiling
) (
	input  wire logic ref_clk_in,
	input  wire logic line_in,
	output logic      drive_low_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial drive_low_out = 1'b0;

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask

	// full reset, then time the presence reply from the released line
	task automatic reset_seq(output int wait_c, output int low_c);
		wait_c = 0;
		low_c = 0;
		drive_low_out = 1'b1;
		tick(RST_LOW_CYC);
		drive_low_out = 1'b0;
		tick(1); // the wire only resolves after this step; reading it at once sees it still low
		while (line_in && wait_c < 4000) begin
			tick(1);
			wait_c++;
		end
		while (!line_in && low_c < 14000) begin
			tick(1);
			low_c++;
		end
		tick(50);
	endtask

	// short low for a one, low past the slave's sample point for a zero; lsb first
	task automatic write_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			drive_low_out = 1'b1;
			tick(b[i] ? 10 : SLOT_DLY_CYC + 10);
			drive_low_out = 1'b0;
			tick(b[i] ? SLOT_DLY_CYC + 10 : 10);
		end
	endtask

	// sample well inside the slave's hold window after releasing
	task automatic read_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			drive_low_out = 1'b1;
			tick(20);
			drive_low_out = 1'b0;
			tick(SLOT_DLY_CYC / 2 - 20);
			b[i] = line_in;
			tick(SLOT_DLY_CYC / 2 + 20); // next slot only after the slave's hold has ended
		end
	endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the single-wire slave
// assumes the master model is the only other party; line idles high
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOT = 100;
	localparam int CONV = 200;
	localparam int COPY = 200;

	logic        ref_clk_in, resetn_in, drive_low, line, line_out, line_oe_n;
	logic        conv_start, conv_busy, nv_write, present, nv_ready;
	logic [15:0] temp_value, nv_data, nv_rd_data, nv_last;
	logic [7:0]  cnt_remain, cnt_per_deg, upper, lower, got, crc;
	logic [7:0]  sp [9];
	int          err_count = 0, comparisons = 0, cycles = 0;
	int          conv_seen = 0, nv_seen = 0, w, l;

	// open-drain wire with pull-up
	assign line = !drive_low && (line_oe_n || line_out);

	swts_slave #(.CONV_CYC(CONV), .COPY_CYC(COPY), .SLOT_DLY_CYC(SLOT)) swts_slave_inst (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .line_in(line), .line_out(line_out),
		.line_oe_n_out(line_oe_n), .temp_value_in(temp_value), .count_remain_in(cnt_remain),
		.count_per_deg_in(cnt_per_deg), .conv_start_out(conv_start), .conv_busy_out(conv_busy),
		.nv_write_out(nv_write), .nv_data_out(nv_data), .nv_data_in(nv_rd_data),
		.nv_ready_in(nv_ready), .present_out(present));
	// reset shortened to 124 us: the slave only needs 120 us, and five resets must fit the run
	swts_master_model #(.SLOT_DLY_CYC(SLOT), .RST_LOW_CYC(6200)) swts_master_model_inst (
		.ref_clk_in(ref_clk_in), .line_in(line), .drive_low_out(drive_low));

	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	// pulse counting and hang guard
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (conv_start === 1'b1) conv_seen <= conv_seen + 1;
		if (nv_write === 1'b1) begin
			nv_seen <= nv_seen + 1;
			nv_last <= nv_data;
		end
		if (cycles == 100000) begin // five opens of about 16k cycles plus the data slots
			err_count++;
			report_and_stop();
		end
	end

	task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_rng(input int g, input int lo, input int hi);
		comparisons++;
		if (g < lo || g > hi) begin
			err_count++;
			$display("MISMATCH t=%0t count %0d not in %0d..%0d", $time, g, lo, hi);
		end
	endtask
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
		return r;
	endfunction
	// reset, presence check, skip addressing, then one function byte
	task automatic open_cmd(input logic [7:0] fn);
		swts_master_model_inst.reset_seq(w, l);
		chk_rng(w, 750, 3000);
		chk_rng(l, 3000, 12000);
		chk_val({15'h0000, present}, 16'h0001);
		swts_master_model_inst.write_byte(8'hcc);
		swts_master_model_inst.write_byte(fn);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		resetn_in = 1'b0;
		nv_ready = 1'b0;
		w = $urandom(84432);
		temp_value = 16'($urandom);
		cnt_remain = 8'($urandom);
		cnt_per_deg = 8'($urandom);
		nv_rd_data = 16'($urandom);
		upper = 8'($urandom);
		lower = 8'h81; // both end bits set
		repeat (10) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		repeat (5) @(negedge ref_clk_in);
		// write triggers, then a surplus byte that must change nothing
		open_cmd(8'h4e);
		swts_master_model_inst.write_byte(upper);
		swts_master_model_inst.write_byte(lower);
		swts_master_model_inst.write_byte(8'h00);
		// read back the whole scratchpad with its check byte
		open_cmd(8'hbe);
		sp = '{temp_value[7:0], temp_value[15:8], upper, lower, 8'hff, 8'hff,
			cnt_remain, cnt_per_deg, 8'h00};
		crc = 8'h00;
		for (int i = 0; i < 8; i++)
			crc = crc_step(crc, sp[i]);
		sp[8] = crc;
		for (int i = 0; i < 9; i++) begin
			swts_master_model_inst.read_byte(got);
			chk_val({8'h00, got}, {8'h00, sp[i]});
		end
		// copy, keep the line high, then a stray command is ignored
		open_cmd(8'h48);
		swts_master_model_inst.tick(COPY + 100);
		chk_val(nv_last, {lower, upper});
		chk_rng(nv_seen, 1, 1);
		swts_master_model_inst.write_byte(8'hbe);
		swts_master_model_inst.read_byte(got);
		chk_val({8'h00, got}, 16'h00ff);
		// convert, hold the line high for the conversion time
		open_cmd(8'h44);
		swts_master_model_inst.tick(CONV + 100);
		chk_rng(conv_seen, 1, 1);
		chk_val({15'h0000, conv_busy}, 16'h0000);
		// recall with storage ready: both triggers reload and show on the storage data
		nv_ready = 1'b1;
		open_cmd(8'hb8);
		swts_master_model_inst.tick(10);
		chk_val(nv_data, nv_rd_data);
		report_and_stop();
	end
endmodule
